// [sli_pkg.sv]
// Package for the status indicator block: register map, fields, timing.
// Assumes a 20 MHz APB clock and 32-bit APB data.
`default_nettype none
package sli_pkg;
  // *****************
  // Register offsets
  // *****************
  localparam logic [7:0] SLI_CTRL_OFS = 8'h00;
  localparam logic [7:0] SLI_STAT_OFS = 8'h04;
  localparam logic [7:0] SLI_CFG_OFS = 8'h08;
  localparam logic [7:0] SLI_SNAP_OFS = 8'h0c;
  // *****************
  // Field layout
  // *****************
  localparam int SLI_STN_LSB = 0;
  localparam int SLI_BAUD_LSB = 8;
  localparam int SLI_SEL_LSB = 16;
  localparam logic [7:0] SLI_STN_MAX = 8'h41;
  localparam logic [7:0] SLI_STN_BAD0 = 8'h00;
  localparam logic [3:0] SLI_BAUD_MAX = 4'h4;
  localparam logic [7:0] SLI_STN_RST = 8'h01;
  localparam logic [3:0] SLI_BAUD_RST = 4'h0;
  localparam int SLI_SNAP_BIT = 0;
  localparam int SLI_UNI_BIT = 8;
  localparam int SLI_RAPID_BIT = 6;
  // *****************
  // State machine codes
  // *****************
  localparam logic [3:0] SLI_SM_INIT = 4'h1;
  localparam logic [3:0] SLI_SM_STATE_PRE_OPERATIONAL = 4'h2;
  localparam logic [3:0] SLI_SM_BOOT = 4'h3;
  localparam logic [3:0] SLI_SM_STATE_SAFE_OPERATIONAL = 4'h4;
  localparam logic [3:0] SLI_SM_OP = 4'h8;
  // *****************
  // Blink timing
  // *****************
  localparam int SLI_CLK_HZ = 20000000;
  localparam int SLI_UNIFORM_MS = 200;
  localparam int SLI_SLOW_ON_MS = 200;
  localparam int SLI_SLOW_OFF_MS = 1000;
  localparam int SLI_RAPID_MS = 50;
  localparam int SLI_TICK_US = 1000;
  localparam int SLI_TICK_CYC = SLI_CLK_HZ / 1000000 * SLI_TICK_US;
  typedef enum logic [1:0] {
    SLI_PH_ON = 2'b00,
    SLI_PH_OFF = 2'b01
  } sli_phase_t;
endpackage
`default_nettype wire

// [sli_led.sv]
// Status LED driver with APB register access.
// Assumes synchronous status inputs from the fieldbus and slave state logic.
//
// Overview of operation
// - Run LED shows slave state: off, uniform, slow, steady, rapid flash.
// - Fieldbus run LED steady when joined and refresh signals received.
// - Fieldbus run LED dark before joining, no carrier, timeout, reset.
// - Error LED steady on CRC error or station number 0 or above 65.
// - Error LED steady when baud-rate selection exceeds 4.
// - Error LED flashes when settings differ from those captured at reset or by the restart command.
// - Error LED dark during good communication and during reset.
// - Receive LED lit while carrier recognized, dark otherwise and in reset.
`default_nettype none
module sli_led
  import sli_pkg::*;
#(
  parameter int TICK_CYC = SLI_TICK_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] slave_state,
  input wire logic net_joined,
  input wire logic refresh_rx,
  input wire logic carrier_present,
  input wire logic comm_timeout,
  input wire logic crc_error,
  input wire logic transmit_busy,
  output logic run_led,
  output logic fieldbus_run_led,
  output logic fieldbus_err_led,
  output logic transmit_activity_led,
  output logic carrier_detect_led
);
  initial
  begin
    // The tick counter is 16 bits wide
    if (TICK_CYC < 1 || TICK_CYC > 65536)
      $error("TICK_CYC must lie between 1 and 65536");
  end

  // *****************
  // Registers and timebase
  // *****************
  logic [7:0] stn_q, stn_d, snap_stn_q, snap_stn_d;
  logic [3:0] baud_q, baud_d, snap_baud_q, snap_baud_d;
  logic snap_pend_q, snap_pend_d;
  logic [15:0] tick_q, tick_d;
  logic [15:0] ms_q, ms_d;
  logic [31:0] rd_d, rd_q;
  logic acc, wr, stn_bad, baud_bad, changed;
  sli_phase_t ph_q;

  assign acc = psel & penable;
  assign wr = acc & pwrite & clk_en;
  assign pready = 1'b1;
  assign pslverr = acc & ~((paddr == SLI_CTRL_OFS) | (paddr == SLI_STAT_OFS)
    | (paddr == SLI_CFG_OFS) | (paddr == SLI_SNAP_OFS));

  always_comb
  begin
    stn_d = stn_q;
    baud_d = baud_q;
    snap_stn_d = snap_stn_q;
    snap_baud_d = snap_baud_q;
    snap_pend_d = 1'b0;
    if (wr && paddr == SLI_CFG_OFS)
    begin
      stn_d = pwdata[SLI_STN_LSB +: 8];
      baud_d = pwdata[SLI_BAUD_LSB +: 4];
    end
    // Restart command, or first cycle after reset, captures settings
    if (snap_pend_q || (wr && paddr == SLI_CTRL_OFS && pwdata[SLI_SNAP_BIT]))
    begin
      snap_stn_d = stn_d;
      snap_baud_d = baud_d;
    end
    tick_d = tick_q + 16'h0001;
    ms_d = ms_q;
    if (tick_q >= 16'(TICK_CYC - 1))
    begin
      tick_d = 16'h0000;
      ms_d = (ms_q >= 16'(SLI_SLOW_ON_MS + SLI_SLOW_OFF_MS - 1)) ? 16'h0000
        : ms_q + 16'h0001;
    end
    case (paddr)
      SLI_CTRL_OFS: rd_d = 32'h0;
      SLI_STAT_OFS: rd_d = {23'h0, transmit_activity_led, carrier_detect_led,
        fieldbus_err_led, fieldbus_run_led, run_led, slave_state};
      SLI_CFG_OFS: rd_d = {20'h0, baud_q, stn_q};
      SLI_SNAP_OFS: rd_d = {20'h0, snap_baud_q, snap_stn_q};
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stn_q <= SLI_STN_RST;
      baud_q <= SLI_BAUD_RST;
      snap_stn_q <= SLI_STN_RST;
      snap_baud_q <= SLI_BAUD_RST;
      snap_pend_q <= 1'b1;
      tick_q <= 16'h0000;
      ms_q <= 16'h0000;
      rd_q <= 32'h0;
    end
    else if (clk_en)
    begin
      stn_q <= stn_d;
      baud_q <= baud_d;
      snap_stn_q <= snap_stn_d;
      snap_baud_q <= snap_baud_d;
      snap_pend_q <= snap_pend_d;
      tick_q <= tick_d;
      ms_q <= ms_d;
      rd_q <= rd_d;
    end
  end
  assign prdata = rd_q;
  assign ph_q = (ms_q < 16'(SLI_UNIFORM_MS)) ? SLI_PH_ON : SLI_PH_OFF;

  // *****************
  // LED decode
  // *****************
  logic run_d, frun_d, ferr_d, tx_d, rx_d;
  logic run_q, frun_q, ferr_q, tx_q, rx_q;
  logic uni, slow, rapid;
  assign stn_bad = (snap_stn_q == SLI_STN_BAD0) | (snap_stn_q > SLI_STN_MAX);
  assign baud_bad = snap_baud_q > SLI_BAUD_MAX;
  assign changed = (stn_q != snap_stn_q) | (baud_q != snap_baud_q);
  assign uni = ms_q[SLI_UNI_BIT];
  assign slow = ph_q == SLI_PH_ON;
  assign rapid = ms_q[SLI_RAPID_BIT];

  always_comb
  begin
    case (slave_state)
      SLI_SM_INIT: run_d = 1'b0;
      SLI_SM_STATE_PRE_OPERATIONAL: run_d = uni;
      SLI_SM_STATE_SAFE_OPERATIONAL: run_d = slow;
      SLI_SM_OP: run_d = 1'b1;
      SLI_SM_BOOT: run_d = rapid;
      default: run_d = 1'b0;
    endcase
    frun_d = net_joined & refresh_rx & carrier_present & ~comm_timeout;
    if (crc_error || stn_bad || baud_bad)
      ferr_d = 1'b1;
    else if (changed)
      ferr_d = rapid;
    else
      ferr_d = 1'b0;
    rx_d = carrier_present;
    tx_d = transmit_busy;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      frun_q <= 1'b0;
      ferr_q <= 1'b0;
      rx_q <= 1'b0;
      tx_q <= 1'b0;
    end
    else if (clk_en)
    begin
      run_q <= run_d;
      frun_q <= frun_d;
      ferr_q <= ferr_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end
  assign run_led = run_q;
  assign fieldbus_run_led = frun_q;
  assign fieldbus_err_led = ferr_q;
  assign carrier_detect_led = rx_q;
  assign transmit_activity_led = tx_q;

  // *****************
  // Assertions
  // *****************
  op_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && slave_state == SLI_SM_OP |=> run_led)
    else $error("run LED not on in operational");
  init_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && slave_state == SLI_SM_INIT |=> !run_led)
    else $error("run LED lit in init");
  frun_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && net_joined && refresh_rx && carrier_present && !comm_timeout
    |=> fieldbus_run_led)
    else $error("fieldbus run LED not lit");
  frun_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (!net_joined || !carrier_present || comm_timeout)
    |=> !fieldbus_run_led)
    else $error("fieldbus run LED lit while down");
  crc_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (crc_error || stn_bad) |=> fieldbus_err_led)
    else $error("error LED not lit on fault");
  baud_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && baud_bad |=> fieldbus_err_led)
    else $error("error LED not lit on baud fault");
  chg_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && changed && !crc_error && !stn_bad && !baud_bad
    |=> fieldbus_err_led == $past(rapid))
    else $error("error LED not flashing on change");
  err_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !changed && !crc_error && !stn_bad && !baud_bad
    |=> !fieldbus_err_led)
    else $error("error LED lit without fault");
  rx_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> carrier_detect_led == $past(carrier_present))
    else $error("carrier LED mismatch");
  tx_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> transmit_activity_led == $past(transmit_busy))
    else $error("transmit LED mismatch");
endmodule // sli_led
`default_nettype wire

// [test_sli_led.sv]
// Testbench for sli_led: LED drives and APB settings registers.
// Assumes sli_pkg is compiled first; no other modules needed.
`default_nettype none
module test_sli_led
  import sli_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ***********
  // Signals
  // ***********
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, run, frun, err, txl, rxl, slv;
  logic tx = 1, car = 1, crc = 1, tmo = 0, jn = 1, rf = 1, ce = 1;
  logic [31:0] rd;
  logic [3:0] st = SLI_SM_OP;
  logic [15:0] q[$];
  string nq[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int run_ups = 0;
  int err_ups = 0;
  logic [7:0] stn;
  event smp;
  always #25 pclk = ~pclk;
  sli_led #(.TICK_CYC(2)) i_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slave_state(st), .net_joined(jn),
    .refresh_rx(rf), .carrier_present(car), .comm_timeout(tmo),
    .crc_error(crc), .transmit_busy(tx), .run_led(run),
    .fieldbus_run_led(frun), .fieldbus_err_led(err),
    .transmit_activity_led(txl), .carrier_detect_led(rxl));
  always @(posedge run) run_ups++;
  always @(posedge err) err_ups++;
  // ***********
  // Checking
  // ***********
  task automatic cmp(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(smp)
  begin
    string nm;
    logic [15:0] seen;
    nm = nq.pop_front();
    case (nm)
      "leds": seen = {11'h0, run, frun, err, txl, rxl};
      "err": seen = {15'h0, err};
      "slverr": seen = {15'h0, slv};
      "rdcfg": seen = rd[15:0];
      "runflash": seen = 16'(run_ups >= 2);
      default: seen = 16'(err_ups >= 2);
    endcase
    cmp(nm, seen, q.pop_front());
  end
  task automatic note(string nm, logic [15:0] e, int w);
    nq.push_back(nm);
    q.push_back(e);
    repeat (w) @(posedge pclk);
    #1 -> smp;
    // Next stimulus starts at a rising edge
    @(posedge pclk);
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    slv = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic snap(logic [7:0] s, logic [3:0] b);
    apb(1, SLI_CFG_OFS, {20'h0, b, s});
    @(posedge pclk);
    apb(1, SLI_CTRL_OFS, 32'h1);
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ***********
  // Tests
  // ***********
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    void'($urandom(17067));
    stn = 8'($urandom_range(65, 1));
    note("leds", 16'h00, 7);
    presetn <= 1;
    note("leds", 16'h1f, 3);
    {tmo, crc, tx} <= 3'b100;
    note("leds", 16'h11, 3);
    {tmo, car} <= 2'b00;
    note("leds", 16'h10, 3);
    {car, jn} <= 2'b10;
    note("leds", 16'h11, 3);
    jn <= 1;
    note("leds", 16'h19, 3);
    {ce, tx} <= 2'b01;
    note("leds", 16'h19, 3);
    ce <= 1;
    note("leds", 16'h1b, 3);
    {st, tx} <= {SLI_SM_INIT, 1'b0};
    note("leds", 16'h09, 3);
    $display("test of level indications done");
    for (int i = 0; i < 3; i++)
    begin
      st <= (i == 0) ? SLI_SM_STATE_PRE_OPERATIONAL : (i == 1) ? SLI_SM_STATE_SAFE_OPERATIONAL : SLI_SM_BOOT;
      @(posedge pclk);
      run_ups = 0;
      note("runflash", 16'h1, 5000);
    end
    $display("test of state flashing done");
    snap(8'h00, 4'h0);
    note("err", 16'h1, 4);
    snap(8'h42, 4'h0);
    note("err", 16'h1, 4);
    snap(stn, 4'h5);
    note("err", 16'h1, 4);
    snap(stn, 4'h4);
    note("err", 16'h0, 4);
    apb(1, SLI_CFG_OFS, {20'h0, 4'h3, stn});
    err_ups = 0;
    note("errflash", 16'h1, 600);
    apb(0, SLI_CFG_OFS, 32'h0);
    note("rdcfg", {4'h0, 4'h3, stn}, 0);
    note("slverr", 16'h0, 0);
    apb(0, 8'h10, 32'h0);
    note("slverr", 16'h1, 0);
    $display("test of settings errors done");
    repeat (2) @(posedge pclk);
    conclude();
  end
endmodule // test_sli_led
`default_nettype wire
